// [src/scbf_framer.sv]
// Command data block framer for one servo axis, with APB registers
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps

// Overview of operation
// - Slot chosen by connection order, not node
// - Wide mode takes two adjacent sixteen-byte slots
// - Multibyte fields are little endian
// - Bytes four to fifteen decoded from code
// - Code byte splits into cyclic, non-cyclic
// - Cyclic code bits 6:4 selects bytes 4-7
// - Non-cyclic bits 3:0 selects bytes 8-15
// - Unsupported cyclic code raises second alarm
// - First argument follows cyclic code
// - Second, third arguments follow non-cyclic code
// - Timing count used only in full sync with wide mode
// - Nonzero command/response flag raises first alarm
// - Node address mismatch raises first alarm
module scbf_framer
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mem_wr,
  input wire logic [scbf_pkg::MEM_AW-1:0] mem_addr,
  input wire logic [7:0] mem_data,
  output logic blk_strobe,
  output logic [2:0] cyclic_code,
  output logic [3:0] noncyclic_code,
  output logic [1:0] update_counter,
  output logic [31:0] cyclic_argument,
  output logic [31:0] noncyclic_argument_a,
  output logic [31:0] noncyclic_argument_b,
  output logic [7:0] sync_timing_count,
  output logic alarm_frame,
  output logic alarm_cyclic,
  output logic irq
);
  import scbf_pkg::*;

  logic [4:0] node_address;
  logic wide_mode;
  logic full_sync;
  logic [4:0] slot;
  logic [7:0] supported;
  logic [ST_WIDTH-1:0] status;
  logic [ST_WIDTH-1:0] mask;
  logic [7:0] blk_buf [BLK_BYTES];
  logic blk_end;
  logic [MEM_AW-1:0] base;
  logic [MEM_AW-1:0] offset;
  logic [5:0] blk_len;
  logic hit;
  logic last_hit;
  logic [7:0] hdr;
  logic [7:0] code;
  logic [31:0] arg0_w;
  logic [31:0] arg1_w;
  logic [31:0] arg2_w;
  logic err_frame;
  logic err_cyclic;
  logic wr_en;
  logic [ST_WIDTH-1:0] next_status;
  logic [31:0] next_rdata;
  logic next_err;

  // Gathers four bytes, lowest byte first
  function automatic logic [31:0] le_word(input logic [7:0] b0,
    input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3);
    le_word = {b3, b2, b1, b0};
  endfunction

  // ****************************************************************
  // Slot window in shared memory
  // ****************************************************************
  // slot base address
  assign base = MEM_AW'(slot) << SLOT_SHIFT;
  assign offset = mem_addr - base;
  assign blk_len = wide_mode ? LEN_WIDE : LEN_NARROW;
  // window spans one or two slots
  assign hit = mem_wr && (mem_addr >= base) &&
    (offset < {3'h0, blk_len});
  assign last_hit = hit && (offset == {3'h0, blk_len - 6'h01});

  // Byte capture into the block buffer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < BLK_BYTES; i++)
        blk_buf[i] <= 8'h00;
    end
    else if (hit)
    begin
      blk_buf[offset[4:0]] <= mem_data;
    end
  end

  // Marks the cycle after the final byte lands
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      blk_end <= 1'b0;
    else
      blk_end <= last_hit;
  end

  // ****************************************************************
  // Block decode
  // ****************************************************************
  assign hdr = blk_buf[BYTE_HDR];
  assign code = blk_buf[BYTE_CODE];
  assign arg0_w = le_word(blk_buf[BYTE_ARG0], blk_buf[BYTE_ARG0+1],
    blk_buf[BYTE_ARG0+2], blk_buf[BYTE_ARG0+3]);
  assign arg1_w = le_word(blk_buf[BYTE_ARG1], blk_buf[BYTE_ARG1+1],
    blk_buf[BYTE_ARG1+2], blk_buf[BYTE_ARG1+3]);
  assign arg2_w = le_word(blk_buf[BYTE_ARG2], blk_buf[BYTE_ARG2+1],
    blk_buf[BYTE_ARG2+2], blk_buf[BYTE_ARG2+3]);
  assign err_frame = hdr[HDR_CR_BIT] ||
    (hdr[HDR_NODE_MSB:0] != node_address);
  assign err_cyclic = !supported[code[CODE_CYC_MSB:CODE_CYC_LSB]];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cyclic_code <= CYC_NOP;
      noncyclic_code <= 4'h0;
      update_counter <= 2'h0;
      cyclic_argument <= 32'h0;
      noncyclic_argument_a <= 32'h0;
      noncyclic_argument_b <= 32'h0;
      sync_timing_count <= 8'h00;
    end
    else if (blk_end)
    begin
      cyclic_code <= code[CODE_CYC_MSB:CODE_CYC_LSB];
      noncyclic_code <= code[CODE_NCY_MSB:0];
      update_counter <= hdr[HDR_UPD_MSB:HDR_UPD_LSB];
      cyclic_argument <= arg0_w;
      noncyclic_argument_a <= arg1_w;
      noncyclic_argument_b <= arg2_w;
      // timing count only in full sync with wide mode
      sync_timing_count <= (full_sync && wide_mode) ?
        blk_buf[BYTE_TMG] : 8'h00;
    end
  end

  // Per-block pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      blk_strobe <= 1'b0;
      alarm_frame <= 1'b0;
      alarm_cyclic <= 1'b0;
    end
    else
    begin
      blk_strobe <= blk_end;
      alarm_frame <= blk_end && err_frame;
      alarm_cyclic <= blk_end && err_cyclic;
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign wr_en = psel && penable && pwrite && pready;

  // Read data and error chosen during setup
  always_comb
  begin
    next_rdata = 32'h0;
    next_err = 1'b0;
    case (paddr)
      ADDR_CTRL: next_rdata = {19'h0, slot, 1'b0, full_sync, wide_mode,
        node_address};
      ADDR_SUPP: next_rdata = {24'h0, supported};
      ADDR_STATUS: next_rdata = {29'h0, status};
      ADDR_MASK: next_rdata = {29'h0, mask};
      ADDR_FIELDS: next_rdata = {16'h0, code, hdr};
      ADDR_ARG0: next_rdata = cyclic_argument;
      ADDR_ARG1: next_rdata = noncyclic_argument_a;
      ADDR_ARG2: next_rdata = noncyclic_argument_b;
      default: next_err = 1'b1;
    endcase
  end

  // No wait state: answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && next_err;
      prdata <= (psel && !penable && !pwrite) ? next_rdata : 32'h0;
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      node_address <= NODE_RESET;
      wide_mode <= 1'b0;
      full_sync <= 1'b0;
      slot <= SLOT_RESET;
      supported <= SUPP_RESET;
      mask <= '0;
    end
    else if (wr_en)
    begin
      if (paddr == ADDR_CTRL)
      begin
        node_address <= pwdata[CTRL_NODE_LSB +: 5];
        wide_mode <= pwdata[CTRL_WIDE_BIT];
        full_sync <= pwdata[CTRL_SYNC_BIT];
        slot <= pwdata[CTRL_SLOT_LSB +: 5];
      end
      if (paddr == ADDR_SUPP)
        supported <= pwdata[7:0];
      if (paddr == ADDR_MASK)
        mask <= pwdata[ST_WIDTH-1:0];
    end
  end

  // Sticky status, write one to clear, set wins
  always_comb
  begin
    next_status = status;
    if (wr_en && paddr == ADDR_STATUS)
      next_status = status & ~pwdata[ST_WIDTH-1:0];
    next_status[ST_BLOCK] = next_status[ST_BLOCK] | blk_end;
    next_status[ST_FRAME] = next_status[ST_FRAME] | (blk_end && err_frame);
    next_status[ST_CYCLIC] = next_status[ST_CYCLIC] |
      (blk_end && err_cyclic);
  end

  // Status and interrupt flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status <= '0;
      irq <= 1'b0;
    end
    else
    begin
      status <= next_status;
      irq <= |(status & mask);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_strobe_timing: assert property (last_hit |-> ##2 blk_strobe)
    else $error("block strobe not two cycles after final byte");
  a_narrow_len: assert property (mem_wr && !wide_mode &&
    offset == {3'h0, LEN_NARROW} |-> !hit)
    else $error("narrow block ran past sixteen bytes");
  a_slot_window: assert property (mem_wr && mem_addr < base |-> !hit)
    else $error("byte below slot base captured");
  a_flag_alarm: assert property (blk_end && hdr[HDR_CR_BIT]
    |=> alarm_frame && status[ST_FRAME])
    else $error("flag set without first alarm");
  a_node_alarm: assert property (blk_end &&
    hdr[HDR_NODE_MSB:0] != node_address |=> alarm_frame)
    else $error("node mismatch without first alarm");
  a_cyclic_alarm: assert property (blk_strobe && $stable(supported) |->
    alarm_cyclic == !supported[cyclic_code])
    else $error("second alarm does not match support");
  a_code_split: assert property (blk_strobe |->
    {1'b0, cyclic_code, noncyclic_code} == ($past(code) & 8'h7f))
    else $error("command code split wrong");
  a_arg_order: assert property (blk_strobe |->
    cyclic_argument[7:0] == $past(blk_buf[BYTE_ARG0]) &&
    noncyclic_argument_b[31:24] == $past(blk_buf[BYTE_ARG2+3]))
    else $error("argument byte order wrong");
  a_ncyc_args: assert property (blk_strobe |->
    noncyclic_argument_a == $past(arg1_w) &&
    noncyclic_argument_b == $past(arg2_w))
    else $error("non-cyclic arguments not taken");
  a_timing_off: assert property (blk_strobe && !$past(full_sync)
    |-> sync_timing_count == 8'h00)
    else $error("timing count used outside full sync");
  a_irq_level: assert property (##1 irq == |($past(status) & $past(mask)))
    else $error("interrupt does not follow status and mask");

  c_good_block: cover property (blk_strobe && !alarm_frame && !alarm_cyclic);
  c_wide_block: cover property (blk_strobe && wide_mode);
  c_alarm_irq: cover property (alarm_cyclic ##1 irq);
  c_clear_set: cover property (wr_en && paddr == ADDR_STATUS && blk_end);
endmodule

// [src/scbf_pkg.sv]
// Constants shared by the servo command block framer
package scbf_pkg;
  // ****************************************************************
  // APB register byte offsets
  // ****************************************************************
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_SUPP = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_MASK = 12'h00c;
  localparam logic [11:0] ADDR_FIELDS = 12'h010;
  localparam logic [11:0] ADDR_ARG0 = 12'h014;
  localparam logic [11:0] ADDR_ARG1 = 12'h018;
  localparam logic [11:0] ADDR_ARG2 = 12'h01c;

  // ****************************************************************
  // Control register fields and reset values
  // ****************************************************************
  localparam int CTRL_NODE_LSB = 0;
  localparam int CTRL_WIDE_BIT = 5;
  localparam int CTRL_SYNC_BIT = 6;
  localparam int CTRL_SLOT_LSB = 8;
  localparam logic [4:0] NODE_RESET = 5'h00;
  localparam logic [4:0] SLOT_RESET = 5'h00;
  // Cyclic codes one to four accepted after reset
  localparam logic [7:0] SUPP_RESET = 8'h1e;

  // ****************************************************************
  // Status and mask bit positions
  // ****************************************************************
  localparam int ST_BLOCK = 0;
  localparam int ST_FRAME = 1;
  localparam int ST_CYCLIC = 2;
  localparam int ST_WIDTH = 3;

  // ****************************************************************
  // Shared memory and block layout
  // ****************************************************************
  localparam int MEM_AW = 9;
  localparam int SLOT_SHIFT = 4;
  localparam logic [5:0] LEN_NARROW = 6'h10;
  localparam logic [5:0] LEN_WIDE = 6'h20;
  localparam int BLK_BYTES = 32;
  localparam int BYTE_HDR = 0;
  localparam int BYTE_CODE = 1;
  localparam int BYTE_ARG0 = 4;
  localparam int BYTE_ARG1 = 8;
  localparam int BYTE_ARG2 = 12;
  localparam int BYTE_TMG = 16;

  // ****************************************************************
  // Header and command code fields
  // ****************************************************************
  localparam int HDR_CR_BIT = 7;
  localparam int HDR_NODE_MSB = 4;
  localparam int HDR_UPD_MSB = 6;
  localparam int HDR_UPD_LSB = 5;
  localparam int CODE_CYC_MSB = 6;
  localparam int CODE_CYC_LSB = 4;
  localparam int CODE_NCY_MSB = 3;
  localparam logic [2:0] CYC_NOP = 3'h0;
endpackage

// [tb/scbf_host.sv]
// Host model that writes command blocks into the shared memory
`timescale 1ns/1ps
module scbf_host
(
  input wire logic pclk,
  output logic mem_wr,
  output logic [scbf_pkg::MEM_AW-1:0] mem_addr,
  output logic [7:0] mem_data
);
  import scbf_pkg::*;
  logic [1:0] upd = 2'h0;
  logic [7:0] b [32];
  initial
  begin
    mem_wr = 1'b0;
    mem_addr = 9'h000;
    mem_data = 8'h00;
  end
  task automatic send(input logic [8:0] base, input logic [5:0] len,
    input logic cr, input logic [4:0] node, input logic [7:0] code,
    input logic [31:0] a0, a1, a2, input logic [7:0] tmg);
    upd = upd + 2'h1;
    for (int i = 0; i < 32; i++)
      b[i] = 8'h00;
    b[0] = {cr, upd, node};
    b[1] = code;
    for (int i = 0; i < 4; i++)
    begin
      b[4 + i] = a0[8 * i +: 8];
      b[8 + i] = a1[8 * i +: 8];
      b[12 + i] = a2[8 * i +: 8];
    end
    b[16] = tmg;
    for (int i = 0; i < len; i++)
    begin
      @(posedge pclk);
      mem_wr <= 1'b1;
      mem_addr <= base + 9'(i);
      mem_data <= b[i];
    end
    @(posedge pclk);
    mem_wr <= 1'b0;
    mem_data <= ~mem_data; // Released bus shows no stale byte
  endtask
endmodule

// [tb/tb.sv]
// Self-checking testbench for the command block framer
`timescale 1ns/1ps
module tb;
  import scbf_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, mem_wr, blk_strobe;
  logic pready, pslverr, alarm_frame, alarm_cyclic, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, arg_c, arg_a, arg_b;
  logic [8:0] mem_addr;
  logic [7:0] mem_data, sync_cnt;
  logic [2:0] cyc;
  logic [3:0] ncy;
  logic [1:0] upd, upd_e;
  int error_cnt = 0;
  int n_tests = 0;
  scbf_framer scbf_framer_inst (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_data(mem_data), .blk_strobe(blk_strobe), .cyclic_code(cyc),
    .noncyclic_code(ncy), .update_counter(upd),
    .cyclic_argument(arg_c), .noncyclic_argument_a(arg_a),
    .noncyclic_argument_b(arg_b), .sync_timing_count(sync_cnt),
    .alarm_frame(alarm_frame), .alarm_cyclic(alarm_cyclic), .irq(irq));
  scbf_host scbf_host_inst (.pclk(pclk), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_data(mem_data));
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // APB transfer held until pready
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] wd, input logic [31:0] exp, input logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(32'(pready), 32'h1);
    if (!wr)
      chk(prdata, exp);
    chk(32'(pslverr), 32'(err));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Send one block and judge the decoded outputs
  task automatic blk(input logic [8:0] base, input logic [5:0] len,
    input logic cr, input logic [4:0] node, input logic [7:0] code,
    input logic [7:0] tmg, etmg, input logic hit_e, af_e, ac_e);
    logic hit;
    logic [31:0] a0;
    hit = 1'b0;
    a0 = 32'h44332211 ^ {4{code}};
    upd_e = upd_e + 2'h1;
    scbf_host_inst.send(base, len, cr, node, code, a0, ~a0,
      {a0[15:0], a0[31:16]}, tmg);
    for (int i = 0; i < 8 && !hit; i++)
    begin
      @(posedge pclk);
      hit = blk_strobe === 1'b1;
    end
    chk(32'(hit), 32'(hit_e));
    if (hit)
    begin
      chk(32'(cyc), 32'(code[6:4]));
      chk(32'(ncy), 32'(code[3:0]));
      chk(arg_c, a0);
      chk(arg_a, ~a0);
      chk(arg_b, {a0[15:0], a0[31:16]});
      chk(32'(upd), 32'(upd_e));
      chk(32'(sync_cnt), 32'(etmg));
      chk(32'(alarm_frame), 32'(af_e));
      chk(32'(alarm_cyclic), 32'(ac_e));
    end
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs();
    apb(1'b0, ADDR_CTRL, 32'h0, 32'h0, 1'b0);
    apb(1'b0, ADDR_SUPP, 32'h0, 32'h1e, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0, 32'h0, 1'b0);
    apb(1'b0, ADDR_MASK, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 12'h020, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 12'h020, 32'h5, 32'h0, 1'b1);
    $display("test regs done");
  endtask
  task automatic t_modes();
    // Each control mode code one to four in turn
    for (int c = 1; c < 5; c++)
      blk(9'h000, LEN_NARROW, 1'b0, 5'h00, 8'(c * 13 + 12), 8'h00,
        8'h00, 1'b1, 1'b0, 1'b0);
    $display("test modes done");
  endtask
  task automatic t_alarms();
    apb(1'b1, ADDR_CTRL, 32'h7, 32'h0, 1'b0);
    blk(9'h0, LEN_NARROW, 1'b0, 5'h07, 8'h21, 8'h0, 8'h0, 1, 0, 0);
    blk(9'h0, LEN_NARROW, 1'b0, 5'h03, 8'h21, 8'h0, 8'h0, 1, 1, 0);
    blk(9'h0, LEN_NARROW, 1'b1, 5'h07, 8'h21, 8'h0, 8'h0, 1, 1, 0);
    blk(9'h0, LEN_NARROW, 1'b0, 5'h07, 8'h03, 8'h0, 8'h0, 1, 0, 1);
    blk(9'h0, LEN_NARROW, 1'b0, 5'h07, 8'h52, 8'h0, 8'h0, 1, 0, 1);
    // Only code six accepted, then readback of the held block
    apb(1'b1, ADDR_SUPP, 32'h40, 32'h0, 1'b0);
    blk(9'h0, LEN_NARROW, 1'b0, 5'h07, 8'h61, 8'h0, 8'h0, 1, 0, 0);
    apb(1'b0, ADDR_FIELDS, 32'h0, 32'h6147, 1'b0);
    apb(1'b0, ADDR_ARG0, 32'h0, 32'h25524370, 1'b0);
    apb(1'b0, ADDR_ARG2, 32'h0, 32'h43702552, 1'b0);
    apb(1'b1, ADDR_SUPP, 32'h1e, 32'h0, 1'b0);
    $display("test alarms done");
  endtask
  task automatic t_slots();
    apb(1'b1, ADDR_CTRL, 32'h200, 32'h0, 1'b0);
    blk(9'h0, LEN_NARROW, 1'b0, 5'h0, 8'h1a, 8'h0, 8'h0, 0, 0, 0);
    blk(9'h20, LEN_NARROW, 1'b0, 5'h0, 8'h1a, 8'h0, 8'h0, 1, 0, 0);
    blk(9'h30, LEN_NARROW, 1'b0, 5'h0, 8'h1a, 8'h0, 8'h0, 0, 0, 0);
    apb(1'b1, ADDR_CTRL, 32'h260, 32'h0, 1'b0);
    blk(9'h20, LEN_NARROW, 1'b0, 5'h0, 8'h2b, 8'h0, 8'h0, 0, 0, 0);
    blk(9'h20, LEN_WIDE, 1'b0, 5'h0, 8'h2b, 8'h5a, 8'h5a, 1, 0, 0);
    apb(1'b1, ADDR_CTRL, 32'h220, 32'h0, 1'b0);
    blk(9'h20, LEN_WIDE, 1'b0, 5'h0, 8'h3c, 8'h5a, 8'h0, 1, 0, 0);
    $display("test slots done");
  endtask
  task automatic t_irq();
    apb(1'b1, ADDR_CTRL, 32'h0, 32'h0, 1'b0);
    apb(1'b1, ADDR_STATUS, 32'h7, 32'h0, 1'b0);
    apb(1'b1, ADDR_MASK, 32'h4, 32'h0, 1'b0);
    blk(9'h0, LEN_NARROW, 1'b0, 5'h0, 8'h61, 8'h0, 8'h0, 1, 0, 1);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0, 32'h5, 1'b0);
    apb(1'b1, ADDR_STATUS, 32'h4, 32'h0, 1'b0);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0, 32'h1, 1'b0);
    apb(1'b0, ADDR_MASK, 32'h0, 32'h4, 1'b0);
    $display("test irq done");
  endtask
  task automatic end_of_test();
    $display("Counts: tests=%0d errors=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ************************************************************
  // Clock, reset, sequence and watchdog
  // ************************************************************
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    #100000;
    error_cnt++;
    end_of_test();
  end
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    upd_e = 2'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_modes();
    t_alarms();
    t_slots();
    t_irq();
    end_of_test();
  end
endmodule
